// *** hw/bl_timeout_pkg.sv ***
// Package for the backlight timeout and sink select slice.
// Assumes a single 20 MHz core clock and a byte-wide register port.
package bl_timeout_pkg;

  // Register offsets
  localparam logic [7:0] SINK_GROUP_SELECT_ADDR = 8'h05;
  localparam logic [7:0] OFF_TIMEOUT_SETTING_ADDR = 8'h06;
  localparam logic [7:0] DIM_TIMEOUT_SETTING_ADDR = 8'h07;
  localparam logic [7:0] FADE_RATE_SETTING_ADDR = 8'h08;

  // Reset values
  localparam logic [7:0] SINK_GROUP_SELECT_RST = 8'h00;
  localparam logic [7:0] OFF_TIMEOUT_SETTING_RST = 8'h00;
  localparam logic [7:0] DIM_TIMEOUT_SETTING_RST = 8'h00;
  localparam logic [7:0] FADE_RATE_SETTING_RST = 8'h00;

  // Field layout
  localparam int SINK_COUNT = 7;
  localparam int PERIOD_MSB = 6;
  localparam int FADE_OUT_MSB = 7;
  localparam int FADE_OUT_LSB = 4;
  localparam int FADE_IN_MSB = 3;
  localparam int FADE_IN_LSB = 0;
  localparam logic [7:0] USED_BITS_MASK = 8'h7F;
  localparam logic [6:0] PERIOD_DISABLED = 7'h00;
  localparam logic [6:0] PERIOD_LAST = 7'h01;

  // Timing: one tick per second at the core clock rate
  localparam longint CLK_HZ = 20000000;
  localparam longint TICK_PERIOD_MS = 1000;
  localparam int TICK_CYCLES_DEF = int'((CLK_HZ * TICK_PERIOD_MS) / 1000);
  localparam int PRESCALE_W = 25;

  // Register write request
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_wr_t;

  // Timeout sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_WAIT_MAX = 6'b000010,
    ST_DIM_RUN = 6'b000100,
    ST_OFF_RUN = 6'b001000,
    ST_HOLD = 6'b010000,
    ST_OFF = 6'b100000
  } tmo_state_t;

endpackage

// *** hw/backlight_timeout_sink_select.sv ***
// Backlight sink grouping plus dim and off timeouts, with its register file.
// Assumes all inputs are generated on clk by the core (no synchronisers needed)
// and that the fade engine reports when the backlight current sits at maximum.
module backlight_timeout_sink_select
  import bl_timeout_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire reg_wr_t reg_wr,
  input wire logic common_backlight_on,
  input wire logic bl_at_max,
  input wire logic [SINK_COUNT-1:0] indep_sink_on,
  output logic [7:0] reg_rdata,
  output logic [SINK_COUNT-1:0] sink_on,
  output logic dim_target,
  output logic bl_timed_off,
  output logic [3:0] fade_out_rate,
  output logic [3:0] fade_in_rate
);

  logic [7:0] sel_r, sel_nxt;
  logic [7:0] off_r, off_nxt;
  logic [7:0] dim_r, dim_nxt;
  logic [7:0] fade_r, fade_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  tmo_state_t state_r, state_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  logic [PRESCALE_W-1:0] pre_r, pre_nxt;
  logic tick_r, tick_nxt;
  logic dimmed_r, dimmed_nxt;
  logic timed_off_r, timed_off_nxt;
  logic [SINK_COUNT-1:0] sink_r, sink_nxt;
  logic wr_timeout;
  logic bl_live;

  assign wr_timeout = reg_wr.we &&
    (reg_wr.addr == OFF_TIMEOUT_SETTING_ADDR || reg_wr.addr == DIM_TIMEOUT_SETTING_ADDR);

  // Register file; reserved bit 7 of the select and timeout registers is never stored so it reads zero
  always_comb begin
    sel_nxt = sel_r;
    off_nxt = off_r;
    dim_nxt = dim_r;
    fade_nxt = fade_r;
    if (reg_wr.we) begin
      case (reg_wr.addr)
        SINK_GROUP_SELECT_ADDR: sel_nxt = reg_wr.wdata & USED_BITS_MASK;
        OFF_TIMEOUT_SETTING_ADDR: off_nxt = reg_wr.wdata & USED_BITS_MASK;
        DIM_TIMEOUT_SETTING_ADDR: dim_nxt = reg_wr.wdata & USED_BITS_MASK;
        FADE_RATE_SETTING_ADDR: fade_nxt = reg_wr.wdata;
        default: ;
      endcase
    end
    case (reg_wr.addr)
      SINK_GROUP_SELECT_ADDR: rdata_nxt = sel_r;
      OFF_TIMEOUT_SETTING_ADDR: rdata_nxt = off_r;
      DIM_TIMEOUT_SETTING_ADDR: rdata_nxt = dim_r;
      FADE_RATE_SETTING_ADDR: rdata_nxt = fade_r;
      default: rdata_nxt = 8'h00; // Unmapped reads return zero
    endcase
  end

  // One-second prescaler; restarted on a timeout write so the first second is whole
  always_comb begin
    tick_nxt = 1'b0;
    pre_nxt = pre_r + PRESCALE_W'(1);
    if (wr_timeout) begin
      pre_nxt = '0;
    end else if (pre_r == PRESCALE_W'(TICK_CYCLES - 1)) begin
      pre_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  // Timeout sequencer: wait for maximum, dim period, then off period
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dimmed_nxt = dimmed_r;
    if (!common_backlight_on) begin
      state_nxt = ST_IDLE;
      dimmed_nxt = 1'b0;
    end else if (wr_timeout) begin
      // New setting restarts from full brightness
      state_nxt = ST_WAIT_MAX;
      dimmed_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: state_nxt = ST_WAIT_MAX;
        ST_WAIT_MAX: begin
          if (bl_at_max) begin
            if (dim_r[PERIOD_MSB:0] != PERIOD_DISABLED) begin
              state_nxt = ST_DIM_RUN;
              cnt_nxt = dim_r[PERIOD_MSB:0];
            end else if (off_r[PERIOD_MSB:0] != PERIOD_DISABLED) begin
              state_nxt = ST_OFF_RUN;
              cnt_nxt = off_r[PERIOD_MSB:0];
            end else begin
              state_nxt = ST_HOLD;
            end
          end
        end
        ST_DIM_RUN: begin
          if (tick_r) begin
            cnt_nxt = cnt_r - 7'h01;
            if (cnt_r == PERIOD_LAST) begin
              dimmed_nxt = 1'b1;
              if (off_r[PERIOD_MSB:0] != PERIOD_DISABLED) begin
                state_nxt = ST_OFF_RUN;
                cnt_nxt = off_r[PERIOD_MSB:0];
              end else begin
                state_nxt = ST_HOLD;
              end
            end
          end
        end
        ST_OFF_RUN: begin
          if (tick_r) begin
            cnt_nxt = cnt_r - 7'h01;
            if (cnt_r == PERIOD_LAST) begin
              state_nxt = ST_OFF;
            end
          end
        end
        ST_HOLD: ;
        ST_OFF: ;
        default: state_nxt = ST_IDLE;
      endcase
    end
    // Registered copy so the off flag leaves a flip-flop, not a state decode
    timed_off_nxt = (state_nxt == ST_OFF);
  end

  // Sink routing; timed-off backlight leaves independent sinks untouched
  assign bl_live = common_backlight_on && (state_r != ST_OFF);
  always_comb begin
    for (int i = 0; i < SINK_COUNT; i++) begin
      sink_nxt[i] = sel_r[i] ? indep_sink_on[i] : bl_live;
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_r <= SINK_GROUP_SELECT_RST;
      off_r <= OFF_TIMEOUT_SETTING_RST;
      dim_r <= DIM_TIMEOUT_SETTING_RST;
      fade_r <= FADE_RATE_SETTING_RST;
      rdata_r <= 8'h00;
      state_r <= ST_IDLE;
      cnt_r <= 7'h00;
      pre_r <= '0;
      tick_r <= 1'b0;
      dimmed_r <= 1'b0;
      timed_off_r <= 1'b0;
      sink_r <= '0;
    end else begin
      sel_r <= sel_nxt;
      off_r <= off_nxt;
      dim_r <= dim_nxt;
      fade_r <= fade_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      tick_r <= tick_nxt;
      dimmed_r <= dimmed_nxt;
      timed_off_r <= timed_off_nxt;
      sink_r <= sink_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign sink_on = sink_r;
  assign dim_target = dimmed_r;
  assign bl_timed_off = timed_off_r;
  assign fade_out_rate = fade_r[FADE_OUT_MSB:FADE_OUT_LSB];
  assign fade_in_rate = fade_r[FADE_IN_MSB:FADE_IN_LSB];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence dim_expiry_s;
    state_r == ST_DIM_RUN && tick_r && cnt_r == PERIOD_LAST && !wr_timeout &&
      common_backlight_on;
  endsequence

  sequence off_expiry_s;
    state_r == ST_OFF_RUN && tick_r && cnt_r == PERIOD_LAST && !wr_timeout &&
      common_backlight_on;
  endsequence

  sink_map_a: assert property (
    !sel_r[0] && !reg_wr.we && state_r == ST_OFF && common_backlight_on |=> !sink_on[0])
    else $error("grouped sink stays on after timeout");
  off_disabled_a: assert property (
    state_r == ST_WAIT_MAX && bl_at_max && dim_r == 8'h00 && off_r == 8'h00 &&
      !wr_timeout && common_backlight_on |=> state_r == ST_HOLD)
    else $error("zero periods did not hold");
  off_expire_a: assert property (
    off_expiry_s |=> bl_timed_off ##1
      (sink_on == ($past(sel_r[SINK_COUNT-1:0]) & $past(indep_sink_on))))
    else $error("off period did not switch backlight off");
  dim_first_a: assert property (
    dim_expiry_s and (off_r != 8'h00) |=> state_r == ST_OFF_RUN &&
      cnt_r == $past(off_r[6:0]))
    else $error("off count not started after dim");
  dim_load_a: assert property (
    state_r == ST_WAIT_MAX && bl_at_max && dim_r != 8'h00 && !wr_timeout &&
      common_backlight_on |=> state_r == ST_DIM_RUN && cnt_r == $past(dim_r[6:0]))
    else $error("dim period not loaded");
  dim_expire_a: assert property (
    dim_expiry_s |=> dim_target && !$past(dim_target))
    else $error("dim target not raised at expiry");
  wait_max_a: assert property (
    state_r == ST_WAIT_MAX && !bl_at_max && !wr_timeout && common_backlight_on
      |=> state_r == ST_WAIT_MAX && !dim_target)
    else $error("dim timing began before maximum");
  fade_field_a: assert property (
    reg_wr.we && reg_wr.addr == FADE_RATE_SETTING_ADDR |=>
      fade_out_rate == $past(reg_wr.wdata[7:4]))
    else $error("fade out nibble not stored");
  write_restart_a: assert property (
    wr_timeout && common_backlight_on |=> state_r == ST_WAIT_MAX && pre_r == '0 ##1 !tick_r)
    else $error("timeout write did not restart");

endmodule

// *** tb/backlight_timeout_sink_select_bench.sv ***
// Self-checking bench for the backlight timeout and sink select slice.
// Assumes the design package is compiled first; the bench drives every port itself.
module backlight_timeout_sink_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import bl_timeout_pkg::*;
  localparam int TICKS = 4;
  logic clk;
  logic rst_n;
  reg_wr_t reg_wr;
  logic common_backlight_on;
  logic bl_at_max;
  logic [SINK_COUNT-1:0] indep_sink_on;
  logic [7:0] reg_rdata;
  logic [SINK_COUNT-1:0] sink_on;
  logic dim_target;
  logic bl_timed_off;
  logic [3:0] fade_out_rate;
  logic [3:0] fade_in_rate;
  int err_count;
  int samples_checked;
  int seed;
  int model_regs [int];
  int cyc;
  logic [7:0] sel;

  backlight_timeout_sink_select #(.TICK_CYCLES(TICKS)) u_dut (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .common_backlight_on(common_backlight_on),
    .bl_at_max(bl_at_max), .indep_sink_on(indep_sink_on), .reg_rdata(reg_rdata),
    .sink_on(sink_on), .dim_target(dim_target), .bl_timed_off(bl_timed_off),
    .fade_out_rate(fade_out_rate), .fade_in_rate(fade_in_rate)
  );

  // Free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      err_count++;
    end
  endtask

  // Inputs always move 5 ns after the rising edge
  task automatic step();
    @(posedge clk);
    #5;
  endtask

  // Write strobe plus model update; bit 7 of the timeout and select registers is not kept
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = '{we: 1'b1, addr: a, wdata: d};
    step();
    reg_wr.we = 1'b0;
    if (model_regs.exists(a)) begin
      model_regs[a] = (a == FADE_RATE_SETTING_ADDR) ? d : (d & 8'h7F);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    reg_wr.addr = a;
    step();
    check(reg_rdata, model_regs.exists(a) ? 8'(model_regs[a]) : 8'h00);
  endtask

  // Bounded wait for the dim or the off flag; running out ends the run
  task automatic wait_flag(input bit off_flag, output int n);
    n = 0;
    while ((off_flag ? bl_timed_off : dim_target) !== 1'b1 && n <= 1000) begin
      step();
      n++;
    end
    if (n > 1000) begin
      err_count++;
      complete_run();
    end
  endtask

  // Period of N seconds must land between N-1 and N ticks plus pipeline slack
  task automatic in_range(input int n, input int code);
    check({7'h00, n > (code - 1) * TICKS && n <= code * TICKS + 3}, 8'h01);
  endtask

  // One full timeout sequence with the given dim and off codes
  task automatic run_seq(input int d, input int o);
    common_backlight_on = 1'b0;
    step();
    wr(OFF_TIMEOUT_SETTING_ADDR, 8'(o));
    wr(DIM_TIMEOUT_SETTING_ADDR, 8'(d));
    common_backlight_on = 1'b1;
    repeat (d * TICKS + 8) step();
    check({6'h00, dim_target, bl_timed_off}, 8'h00);
    bl_at_max = 1'b1;
    if (d != 0) begin
      wait_flag(1'b0, cyc);
      in_range(cyc, d);
      check({7'h00, bl_timed_off}, 8'h00);
    end
    if (o != 0) begin
      wait_flag(1'b1, cyc);
      in_range(cyc, o);
      check({7'h00, dim_target}, {7'h00, d != 0});
      step();
      step();
      check({1'b0, sink_on}, {1'b0, sel[6:0] & indep_sink_on});
    end else begin
      repeat (3 * TICKS + 4) step();
      check({7'h00, bl_timed_off}, 8'h00);
    end
    bl_at_max = 1'b0;
  endtask

  // Main sequence
  initial begin
    seed = 10;
    err_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    reg_wr = '0;
    common_backlight_on = 1'b0;
    bl_at_max = 1'b0;
    indep_sink_on = '0;
    sel = 8'h00;
    for (int a = 5; a <= 8; a++) model_regs[a] = 0;
    repeat (10) step();
    rst_n = 1'b1;
    for (int a = 4; a <= 9; a++) rd(8'(a));
    // Random register traffic, including an unmapped place
    for (int i = 0; i < 12; i++) begin
      wr(8'(5 + i % 5), 8'($random(seed)));
      rd(8'(5 + i % 5));
    end
    rd(FADE_RATE_SETTING_ADDR);
    check({fade_out_rate, fade_in_rate}, 8'(model_regs[8]));
    // Sink grouping against random selects and requests
    for (int i = 0; i < 20; i++) begin
      sel = 8'($random(seed));
      wr(SINK_GROUP_SELECT_ADDR, sel);
      indep_sink_on = 7'($random(seed));
      common_backlight_on = 1'($random(seed));
      step();
      step();
      check({1'b0, sink_on}, {1'b0, (sel[6:0] & indep_sink_on) |
        (~sel[6:0] & {7{common_backlight_on}})});
    end
    sel = 8'h55;
    wr(SINK_GROUP_SELECT_ADDR, sel);
    indep_sink_on = 7'h7F;
    run_seq(2, 3);
    run_seq(0, 2);
    run_seq(1, 0);
    run_seq(0, 0);
    run_seq(1, 1);
    // Rewriting the dim period mid-run clears the flags and starts a whole new period
    bl_at_max = 1'b1;
    wr(DIM_TIMEOUT_SETTING_ADDR, 8'h02);
    check({6'h00, dim_target, bl_timed_off}, 8'h00);
    repeat (TICKS) step();
    wr(DIM_TIMEOUT_SETTING_ADDR, 8'h02);
    wait_flag(1'b0, cyc);
    check(8'(cyc), 8'(2 * TICKS + 1));
    // Second reset mid-run clears registers and timeout flags
    rst_n = 1'b0;
    repeat (2) step();
    rst_n = 1'b1;
    for (int a = 5; a <= 8; a++) model_regs[a] = 0;
    check({sink_on, dim_target}, 8'h00);
    check({7'h00, bl_timed_off}, 8'h00);
    rd(DIM_TIMEOUT_SETTING_ADDR);
    complete_run();
  end
endmodule
